// ---- logic/pswc_pkg.sv ----
// Constants, types and helpers for the power-state and wake controller
// Functional notes
// - One run state D0, two saving states D1, D2; sleeping, only control reg reads.
// - Entering D1 or D2 clears ready until the return to D0 completes.
// - Host writes are ignored after reset or wake until one host read occurs.
// - Any write to the test register in D1/D2 returns to D0, state field 00.
// - State field 01 enters D1; PHY and receive clocks run, others gated.
// - D1 enables frame detection; a detection sets wake status to 10b.
// - D1 frame detection drives wake pin when frame and pin enables set.
// - Wake interrupt status sets on any wake event, pin enable irrelevant.
// - D2 carrier with energy and pin enables drives pin; wake status 01b.
// - Wake status holds while internal event active; host clears by writing 1.
// - Pulse select 1 gives a 50 ms pin pulse; 0 holds the pin active.
// - Pin drops when wake status, matching enable or pin enable is cleared.
// - PHY general power-down bit keeps PHY off; clearing it resets the PHY.
// - Energy power-down with no line energy powers PHY down, no transmit.
// - Energy arrival powers PHY up and sets its energy flag, may interrupt.
// - All configuration is retained across D1 and D2.
// - Ready sets within 2 ms after the wake write.
package pswc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] PMC_OFS = 8'h00;
  localparam logic [7:0] INTSTS_OFS = 8'h04;
  localparam logic [7:0] INTEN_OFS = 8'h08;
  localparam logic [7:0] WTEST_OFS = 8'h0C;
  localparam logic [7:0] PHYCTL_OFS = 8'h10;
  localparam logic [7:0] PHYMODE_OFS = 8'h14;
  localparam logic [7:0] PHYIRQ_OFS = 8'h18;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int PMC_READY_BIT = 0;
  localparam int PMC_PINEN_BIT = 1;
  localparam int PMC_PULSE_BIT = 3;
  localparam int PMC_EDEN_BIT = 8;
  localparam int PMC_WOLEN_BIT = 9;
  localparam int PMC_WSTAT_LSB = 12;
  localparam int PMC_PSTATE_LSB = 16;
  localparam int INT_WAKE_BIT = 17;
  localparam int INT_PHY_BIT = 26;
  localparam int PHYCTL_PD_BIT = 11;
  localparam int PHYMODE_EDPD_BIT = 13;
  localparam int PHYIRQ_FLAG_BIT = 1;
  localparam int PHYIRQ_EN_BIT = 9;

  // ----------------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------------
  localparam logic [1:0] PS_D0 = 2'h0;
  localparam logic [1:0] PS_D1 = 2'h1;
  localparam logic [1:0] PS_D2 = 2'h2;
  localparam logic [1:0] WS_ENERGY = 2'h1;
  localparam logic [1:0] WS_FRAME = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] WSTAT_RST = 2'h0;
  localparam logic [1:0] INTEN_RST = 2'h0;
  // Arbitrary fixed pattern returned by the wake test register
  localparam logic [31:0] TEST_PATTERN = 32'h5A5A_C3C3;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned WAKE_READY_NS = 2_000_000;
  localparam int unsigned PIN_PULSE_NS = 50_000_000;
  localparam int unsigned WAKE_READY_CYC = WAKE_READY_NS / CLK_PERIOD_NS;
  localparam int unsigned PIN_PULSE_CYC = PIN_PULSE_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_D0, ST_D1, ST_D2, ST_WAKE} pswc_state_t;

  typedef struct packed {
    logic pin_en;
    logic pulse_sel;
    logic energy_en;
    logic frame_en;
  } pswc_wake_cfg_t;

  typedef struct packed {
    logic gen_pd;
    logic edpd;
    logic irq_en;
  } pswc_phy_cfg_t;

  localparam pswc_wake_cfg_t WAKE_CFG_RST = '{default: 1'b0};
  localparam pswc_phy_cfg_t PHY_CFG_RST = '{default: 1'b0};

  function automatic logic is_sleep(input pswc_state_t s);
    return (s == ST_D1) || (s == ST_D2);
  endfunction

  function automatic logic map_ok(input logic [7:0] a);
    return (a == PMC_OFS) || (a == INTSTS_OFS) || (a == INTEN_OFS) ||
           (a == WTEST_OFS) || (a == PHYCTL_OFS) || (a == PHYMODE_OFS) ||
           (a == PHYIRQ_OFS);
  endfunction

endpackage

// ---- logic/pswc_wake_pin.sv ----
// Wake-event pin driver with pulsed and static modes
`timescale 1ns/1ps
module pswc_wake_pin import pswc_pkg::*; #(
  parameter int unsigned PULSE_CYC = PIN_PULSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire pswc_wake_cfg_t cfg,
  input wire logic wake_evt,
  // Pin
  output logic wake_pin
);

  logic evt_q, evt_d, pin_q, pin_d;
  logic [31:0] cnt_q, cnt_d;
  logic gated;

  always_comb begin
    gated = wake_evt & cfg.pin_en;
    evt_d = gated;
    cnt_d = (cnt_q != 32'h0) ? cnt_q - 32'h1 : 32'h0;
    if (!gated) begin
      cnt_d = 32'h0;
      pin_d = 1'b0;
    end else if (cfg.pulse_sel) begin
      if (!evt_q) begin
        cnt_d = PULSE_CYC;
      end
      pin_d = (cnt_d != 32'h0);
    end else begin
      pin_d = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      evt_q <= 1'b0;
      pin_q <= 1'b0;
      cnt_q <= 32'h0;
    end else begin
      evt_q <= evt_d;
      pin_q <= pin_d;
      cnt_q <= cnt_d;
    end
  end

  assign wake_pin = pin_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_pin_drop: assert property (!cfg.pin_en || !wake_evt |=> !wake_pin)
    else $error("wake pin stayed active without enable or event");
  chk_pin_static: assert property (
    cfg.pin_en && wake_evt && !cfg.pulse_sel ##1 cfg.pin_en && wake_evt
    && !cfg.pulse_sel |-> wake_pin)
    else $error("static wake pin not held");
  chk_pulse_len: assert property (cnt_q <= PULSE_CYC)
    else $error("pulse counter beyond pulse length");

endmodule // pswc_wake_pin

// ---- logic/pswc_phy_power.sv ----
// PHY power-down modes and energy-arrival flag
`timescale 1ns/1ps
module pswc_phy_power import pswc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire pswc_phy_cfg_t cfg,
  input wire logic line_energy,
  input wire logic flag_clr,
  // Status
  output logic energy_present,
  output logic phy_powered,
  output logic phy_auto_reset,
  output logic flag,
  output logic irq
);

  logic en_q, en_d, pw_q, pw_d, pd_q, pd_d, rst_q, rst_d, flag_q, flag_d;

  always_comb begin
    en_d = line_energy;
    // Management interface stays alive in both power-down modes
    pw_d = !cfg.gen_pd && (!cfg.edpd || line_energy);
    pd_d = cfg.gen_pd;
    rst_d = pd_q && !cfg.gen_pd;
    // Energy wake restores prior state, so no reset is issued here
    flag_d = (cfg.edpd && line_energy && !en_q) || (flag_q && !flag_clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= 1'b0;
      pw_q <= 1'b1;
      pd_q <= 1'b0;
      rst_q <= 1'b0;
      flag_q <= 1'b0;
    end else begin
      en_q <= en_d;
      pw_q <= pw_d;
      pd_q <= pd_d;
      rst_q <= rst_d;
      flag_q <= flag_d;
    end
  end

  assign energy_present = en_q;
  assign phy_powered = pw_q;
  assign phy_auto_reset = rst_q;
  assign flag = flag_q;
  assign irq = flag_q && cfg.irq_en;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_phy_pd: assert property (cfg.gen_pd |=> !phy_powered)
    else $error("PHY powered during general power-down");
  chk_phy_edpd: assert property (cfg.edpd && !line_energy |=> !phy_powered)
    else $error("PHY powered without line energy");
  chk_phy_flag: assert property (cfg.edpd && line_energy && !en_q |=> flag)
    else $error("energy arrival flag not set");

endmodule // pswc_phy_power

// ---- logic/pswc_ctrl.sv ----
// Power-state and wake controller with AXI4-Lite register slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pswc_ctrl import pswc_pkg::*; #(
  parameter int unsigned READY_CYC = WAKE_READY_CYC,
  parameter int unsigned PULSE_CYC = PIN_PULSE_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Line side
  input wire logic wake_frame_det,
  input wire logic line_energy,
  // Wake outputs
  output logic wake_pin,
  output logic host_irq,
  // Power control
  output logic [1:0] power_state,
  output logic mac_clk_en,
  output logic hostbus_clk_en,
  output logic rx_pm_clk_en,
  output logic phy_clk_en,
  output logic wake_detect_en,
  output logic phy_powered,
  output logic phy_tx_en,
  output logic phy_auto_reset
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  pswc_state_t state_q, state_d;
  pswc_wake_cfg_t cfg_q, cfg_d;
  pswc_phy_cfg_t phycfg_q, phycfg_d;
  logic [1:0] pstate_q, pstate_d, wstat_q, wstat_d, inten_q, inten_d;
  logic [31:0] cnt_q, cnt_d, rdata_q, rdata_d, wd, w1c;
  logic ready_q, ready_d, seen_q, seen_d, intw_q, intw_d, irq_q, irq_d;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_take, rd_take, frame_hit, energy_hit, pme_int, phy_clr;
  logic energy_present, phy_flag, phy_irq;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] reg_value(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0;
    case (a)
      PMC_OFS: begin
        v[PMC_READY_BIT] = ready_q;
        v[PMC_PINEN_BIT] = cfg_q.pin_en;
        v[PMC_PULSE_BIT] = cfg_q.pulse_sel;
        v[PMC_EDEN_BIT] = cfg_q.energy_en;
        v[PMC_WOLEN_BIT] = cfg_q.frame_en;
        v[PMC_WSTAT_LSB +: 2] = wstat_q;
        v[PMC_PSTATE_LSB +: 2] = pstate_q;
      end
      INTSTS_OFS: begin
        v[INT_WAKE_BIT] = intw_q;
        v[INT_PHY_BIT] = phy_flag;
      end
      INTEN_OFS: begin
        v[INT_WAKE_BIT] = inten_q[0];
        v[INT_PHY_BIT] = inten_q[1];
      end
      WTEST_OFS: v = TEST_PATTERN;
      PHYCTL_OFS: v[PHYCTL_PD_BIT] = phycfg_q.gen_pd;
      PHYMODE_OFS: v[PHYMODE_EDPD_BIT] = phycfg_q.edpd;
      PHYIRQ_OFS: begin
        v[PHYIRQ_FLAG_BIT] = phy_flag;
        v[PHYIRQ_EN_BIT] = phycfg_q.irq_en;
      end
      default: v = 32'h0;
    endcase
    return v;
  endfunction

  // ----------------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------------
  // Address and data are taken together, which keeps one decode path
  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign rd_take = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = !rvalid_q;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    pstate_d = pstate_q;
    ready_d = ready_q;
    cnt_d = cnt_q;
    seen_d = seen_q;
    cfg_d = cfg_q;
    phycfg_d = phycfg_q;
    inten_d = inten_q;
    phy_clr = 1'b0;
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    wd = merge(reg_value(s_axi_awaddr), s_axi_wdata, s_axi_wstrb);
    w1c = merge(32'h0, s_axi_wdata, s_axi_wstrb);
    w1c = wr_take && ready_q && seen_q ? w1c : 32'h0;

    // Resume: ready comes back after the settle count
    if (state_q == ST_WAKE) begin
      cnt_d = cnt_q + 32'h1;
      if (cnt_q >= READY_CYC - 32'h1) begin
        state_d = ST_D0;
        ready_d = 1'b1;
        seen_d = 1'b0;
        cnt_d = 32'h0;
      end
    end

    if (rd_take) begin
      rvalid_d = 1'b1;
      seen_d = 1'b1;
      if ((!ready_q && s_axi_araddr != PMC_OFS) || !map_ok(s_axi_araddr)) begin
        rresp_d = RESP_SLVERR;
        rdata_d = 32'h0;
      end else begin
        rresp_d = RESP_OKAY;
        rdata_d = reg_value(s_axi_araddr);
      end
    end

    if (wr_take) begin
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      if (s_axi_awaddr == WTEST_OFS && is_sleep(state_q)) begin
        state_d = ST_WAKE;
        pstate_d = PS_D0;
        cnt_d = 32'h0;
      end else if (!ready_q || !map_ok(s_axi_awaddr)) begin
        bresp_d = RESP_SLVERR;
      end else if (seen_q) begin
        case (s_axi_awaddr)
          PMC_OFS: begin
            cfg_d.pin_en = wd[PMC_PINEN_BIT];
            cfg_d.pulse_sel = wd[PMC_PULSE_BIT];
            cfg_d.energy_en = wd[PMC_EDEN_BIT];
            cfg_d.frame_en = wd[PMC_WOLEN_BIT];
            // Reserved encoding 11 and 00 leave the state alone
            if (wd[PMC_PSTATE_LSB +: 2] == PS_D1) begin
              state_d = ST_D1;
              pstate_d = PS_D1;
              ready_d = 1'b0;
            end else if (wd[PMC_PSTATE_LSB +: 2] == PS_D2) begin
              // Host has set energy power-down beforehand
              state_d = ST_D2;
              pstate_d = PS_D2;
              ready_d = 1'b0;
            end
          end
          INTEN_OFS: inten_d = {wd[INT_PHY_BIT], wd[INT_WAKE_BIT]};
          PHYCTL_OFS: phycfg_d.gen_pd = wd[PHYCTL_PD_BIT];
          PHYMODE_OFS: phycfg_d.edpd = wd[PHYMODE_EDPD_BIT];
          PHYIRQ_OFS: begin
            phycfg_d.irq_en = wd[PHYIRQ_EN_BIT];
            phy_clr = w1c[PHYIRQ_FLAG_BIT];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Wake status and interrupt
  // ----------------------------------------------------------------------
  always_comb begin
    frame_hit = (state_q == ST_D1) && wake_frame_det;
    energy_hit = (state_q == ST_D2) && energy_present;
    // A detection in the clearing cycle wins over the clear
    wstat_d = wstat_q;
    if (wr_take && s_axi_awaddr == PMC_OFS) begin
      wstat_d = wstat_q & ~w1c[PMC_WSTAT_LSB +: 2];
    end
    wstat_d = wstat_d | (frame_hit ? WS_FRAME : 2'h0)
                      | (energy_hit ? WS_ENERGY : 2'h0);
    intw_d = pme_int;
    if (!(wr_take && s_axi_awaddr == INTSTS_OFS && w1c[INT_WAKE_BIT])) begin
      intw_d = intw_d || intw_q;
    end
    irq_d = (intw_q && inten_q[0]) || (phy_irq && inten_q[1]);
  end

  assign pme_int = (wstat_q[1] && cfg_q.frame_en) ||
                   (wstat_q[0] && cfg_q.energy_en);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // Configuration is never touched by sleep entry or exit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ST_D0;
      pstate_q <= PS_D0;
      ready_q <= 1'b1;
      cnt_q <= 32'h0;
      seen_q <= 1'b0;
      cfg_q <= WAKE_CFG_RST;
      phycfg_q <= PHY_CFG_RST;
      inten_q <= INTEN_RST;
      wstat_q <= WSTAT_RST;
      intw_q <= 1'b0;
      irq_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0;
      rresp_q <= RESP_OKAY;
    end else begin
      state_q <= state_d;
      pstate_q <= pstate_d;
      ready_q <= ready_d;
      cnt_q <= cnt_d;
      seen_q <= seen_d;
      cfg_q <= cfg_d;
      phycfg_q <= phycfg_d;
      inten_q <= inten_d;
      wstat_q <= wstat_d;
      intw_q <= intw_d;
      irq_q <= irq_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  // ----------------------------------------------------------------------
  // Sub-blocks and outputs
  // ----------------------------------------------------------------------
  pswc_wake_pin #(.PULSE_CYC(PULSE_CYC)) u_pin (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(cfg_q),
    .wake_evt(pme_int),
    .wake_pin(wake_pin)
  );

  pswc_phy_power u_phy (
    .aclk(aclk),
    .aresetn(aresetn),
    .cfg(phycfg_q),
    .line_energy(line_energy),
    .flag_clr(phy_clr),
    .energy_present(energy_present),
    .phy_powered(phy_powered),
    .phy_auto_reset(phy_auto_reset),
    .flag(phy_flag),
    .irq(phy_irq)
  );

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign host_irq = irq_q;
  assign power_state = pstate_q;
  // D1 keeps PHY and receive wake logic clocked; D2 stops all four clocks, the PHY clock included
  assign mac_clk_en = !is_sleep(state_q);
  assign hostbus_clk_en = !is_sleep(state_q);
  assign rx_pm_clk_en = state_q != ST_D2;
  assign phy_clk_en = state_q != ST_D2;
  assign wake_detect_en = state_q == ST_D1;
  assign phy_tx_en = phy_powered;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_sleep_not_ready: assert property (is_sleep(state_q) |-> !ready_q)
    else $error("ready set while sleeping");
  chk_sleep_read_err: assert property (rd_take && !ready_q &&
    s_axi_araddr != PMC_OFS |=> rvalid_q && rresp_q == RESP_SLVERR
    && rdata_q == 32'h0)
    else $error("sleeping read of other register not refused");
  chk_wake_write: assert property (wr_take && s_axi_awaddr == WTEST_OFS &&
    is_sleep(state_q) |=> state_q == ST_WAKE && pstate_q == PS_D0)
    else $error("wake write did not start resume");
  chk_ready_bound: assert property (state_q == ST_WAKE |-> cnt_q < READY_CYC)
    else $error("resume exceeded ready bound");
  chk_ready_back: assert property (state_q == ST_WAKE && cnt_q ==
    READY_CYC - 32'h1 |=> ready_q && state_q == ST_D0 && !seen_q)
    else $error("ready not restored after resume");
  chk_write_first: assert property (wr_take && ready_q && !seen_q &&
    s_axi_awaddr == PMC_OFS |=> $stable(cfg_q) && state_q == ST_D0)
    else $error("write accepted before first read");
  chk_d1_clocks: assert property (state_q == ST_D1 |-> phy_clk_en &&
    rx_pm_clk_en && !mac_clk_en && wake_detect_en)
    else $error("D1 clock gating wrong");
  chk_frame_status: assert property (state_q == ST_D1 && wake_frame_det
    |=> wstat_q[1])
    else $error("frame detection did not set wake status");
  chk_energy_status: assert property (state_q == ST_D2 && energy_present
    |=> wstat_q[0])
    else $error("energy detection did not set wake status");
  chk_int_sticky: assert property (pme_int |=> intw_q ##1 intw_q || !pme_int)
    else $error("wake interrupt status not held");
  chk_irq_path: assert property (intw_q && inten_q[0] |=> host_irq)
    else $error("wake interrupt not raised");
  cov_d1: cover property (state_q == ST_D0 ##1 state_q == ST_D1);
  cov_d2: cover property (state_q == ST_D0 ##1 state_q == ST_D2);
  cov_resume: cover property (state_q == ST_WAKE ##1 state_q == ST_D0);
  cov_pin: cover property ($rose(wake_pin));

endmodule // pswc_ctrl

// ---- testbench/pswc_line.sv ----
// Line-side model: wake frames and carrier energy
`timescale 1ns/1ps
module pswc_line (
  // Clock
  input wire logic aclk,
  // Requests from the bench
  input wire logic send_frame,
  input wire logic carrier_on,
  // Line side of the controller
  output logic wake_frame_det,
  output logic line_energy
);
  // Registered so the detector output lines up with a clock edge
  always_ff @(posedge aclk) begin
    wake_frame_det <= send_frame;
    line_energy <= carrier_on;
  end
endmodule // pswc_line

// ---- testbench/pswc_ctrl_test.sv ----
// Self-checking bench for the power-state and wake controller
`timescale 1ns/1ps
module pswc_ctrl_test import pswc_pkg::*;;
  logic aclk = 0, aresetn = 0, send_frame = 0, carrier_on = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, seed = 18169;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_state;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, wake_frame_det, line_energy, wake_pin, host_irq;
  logic mac_clk_en, hostbus_clk_en, rx_pm_clk_en, phy_clk_en;
  logic wake_detect_en, phy_powered, phy_tx_en, phy_auto_reset;
  logic [33:0] q[$];
  int fail_count = 0, n_tests = 0, cyc = 0;

  pswc_ctrl #(.READY_CYC(20), .PULSE_CYC(16)) dut_u (.*);
  pswc_line line_u (.*);

  initial forever #5 aclk = ~aclk;

  // ----------------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------------
  task automatic chk(input string n, input logic [33:0] s, e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Read results are matched against the oldest note in order
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, q.pop_front());
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ----------------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_awready);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    wr(PMC_OFS, 32'h0000_0302, RESP_OKAY);
    rd(PMC_OFS, {RESP_OKAY, 32'h0000_0001});
    rd(8'h40, {RESP_SLVERR, 32'h0});
    wr(PMC_OFS, 32'h0000_0302, RESP_OKAY);
    wr(INTEN_OFS, 32'h0002_0000, RESP_OKAY);
    rd(PMC_OFS, {RESP_OKAY, 32'h0000_0303});
    wr(PMC_OFS, 32'h0001_0302, RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk("d1", {power_state, mac_clk_en, hostbus_clk_en, rx_pm_clk_en,
        phy_clk_en, wake_detect_en}, {PS_D1, 5'b00111});
    rd(INTEN_OFS, {RESP_SLVERR, 32'h0});
    rd(PMC_OFS, {RESP_OKAY, 32'h0001_0302});
    wr(INTEN_OFS, 32'h0, RESP_SLVERR);
    send_frame <= 1'b1;
    @(posedge aclk);
    send_frame <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("pin", {wake_pin, host_irq}, 2'b11);
    rd(PMC_OFS, {RESP_OKAY, 32'h0001_2302});
    wr(WTEST_OFS, xs(), RESP_OKAY);
    chk("wake", power_state, PS_D0);
    repeat (24) @(posedge aclk);
    rd(PMC_OFS, {RESP_OKAY, 32'h0000_2303});
    wr(PMC_OFS, 32'h0000_2302, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("pin", wake_pin, 1'b0);
    rd(INTSTS_OFS, {RESP_OKAY, 32'h0002_0000});
    wr(INTSTS_OFS, 32'h0002_0000, RESP_OKAY);
    rd(INTSTS_OFS, {RESP_OKAY, 32'h0});
    wr(PHYMODE_OFS, 32'h0000_2000, RESP_OKAY);
    carrier_on <= 1'b1;
    wr(PMC_OFS, 32'h0002_030A, RESP_OKAY);
    repeat (5) @(posedge aclk);
    chk("d2", {wake_pin, power_state, mac_clk_en, hostbus_clk_en,
        rx_pm_clk_en, phy_clk_en}, {1'b1, PS_D2, 4'b0000});
    repeat (20) @(posedge aclk);
    chk("pulse", wake_pin, 1'b0);
    wr(WTEST_OFS, xs(), RESP_OKAY);
    repeat (24) @(posedge aclk);
    rd(PMC_OFS, {RESP_OKAY, 32'h0000_130B});
    rd(PHYIRQ_OFS, {RESP_OKAY, 32'h0000_0002});
    wr(PHYMODE_OFS, 32'h0, RESP_OKAY);
    wr(PHYCTL_OFS, 32'h0000_0800, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("phy_pd", {phy_powered, phy_tx_en}, 2'b00);
    wr(PHYCTL_OFS, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk("phy_up", {phy_powered, phy_tx_en}, 2'b11);
    repeat (4) @(posedge aclk);
    give_verdict();
  end
endmodule // pswc_ctrl_test
